// file: design/lcsp_dev.sv
// lcsp_dev: device end of the serial command port, with its
// byte buffer, data memory, display latch and sync logic
// assumes: link pins are asynchronous to clk; host keeps phases
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// byte buffer
// ------------------------------------------------------------------
module lcsp_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];   // storage
  logic [AW-1:0] wr_q;        // write index
  logic [AW-1:0] rd_q;        // read index
  logic [AW:0]   cnt_q;       // words held
  logic          push;
  logic          pop;
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // pointers wrap at the depth
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

// ------------------------------------------------------------------
// device end
// ------------------------------------------------------------------
module lcsp_dev
  import lcsp_pkg::*;
#(
  parameter int DEPTH = lcsp_pkg::DM_DEPTH,
  parameter int BUF_D = lcsp_pkg::FIFO_DEPTH,
  parameter int FRAME = lcsp_pkg::FRAME_CYC
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // link to host
  lcsp_if.dev                      link,
  // command decoder side
  output logic                     cmd_valid,
  input  wire logic                cmd_ready,
  output logic [BYTE_W-1:0]        cmd_code,
  // segment decoder side
  input  wire logic                seg_dec_en,
  output logic                     seg_valid,
  input  wire logic                seg_ready,
  output logic [BYTE_W-1:0]        seg_byte,
  // display side
  output logic [DEPTH*DM_W-1:0]    disp_latch,
  output logic                     frame_tick
);
  import lcsp_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int FW = $clog2(FRAME);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s1_q;       // first stage, read only by second
  logic [4:0] pin_s2_q;       // {sync, cs_b, cd, si, sck_b}
  logic       sck_prev_q;     // for the rising edge
  logic       cs_prev_q;      // for both select edges
  logic       sync_prev_q;    // for the sync falling edge
  // two flops on every pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s1_q <= 5'h1F;
      pin_s2_q <= 5'h1F;
    end else begin
      pin_s1_q <= {link.sync_b, link.cs_b, link.cd, link.si, link.sck_b};
      pin_s2_q <= pin_s1_q;
    end
  end
  // previous levels for edge detection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sck_prev_q  <= 1'b1;
      cs_prev_q   <= 1'b1;
      sync_prev_q <= 1'b1;
    end else begin
      sck_prev_q  <= pin_s2_q[0];
      cs_prev_q   <= pin_s2_q[3];
      sync_prev_q <= pin_s2_q[4];
    end
  end
  logic sck_rise;
  logic cs_fall;
  logic cs_rise;
  logic sync_fall;
  assign sck_rise  = pin_s2_q[0] & ~sck_prev_q;
  assign cs_fall   = ~pin_s2_q[3] & cs_prev_q;
  assign cs_rise   = pin_s2_q[3] & ~cs_prev_q;
  assign sync_fall = ~pin_s2_q[4] & sync_prev_q;

  // ----------------------------------------------------------------
  // serial register and counter
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] shift_q;   // serial register
  logic [CNT_W-1:0]  cnt_q;     // shift clock counter
  logic              hold_q;    // hold level, 1 = accepting
  logic              pend_q;    // latched byte awaiting buffer
  logic [BYTE_W:0]   cdreg_q;   // {cd, byte} command/data reg
  logic              bufin_rdy;
  logic              accept;
  logic              ovf;
  // edges count only while selected and accepting
  assign accept = sck_rise & ~pin_s2_q[3] & hold_q;
  assign ovf    = accept & (cnt_q == CNT_LAST);
  // shift msb first, one bit per accepted edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shift_q <= '0;
    end else if (accept) begin
      shift_q <= {shift_q[BYTE_W-2:0], pin_s2_q[1]};
    end
  end
  // counter cleared on select, advanced per edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= CNT_RST;
    end else if (cs_fall) begin
      cnt_q <= CNT_RST;
    end else if (accept) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  // command/data register catches the full byte and its marker
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cdreg_q <= '0;
    end else if (ovf) begin
      cdreg_q <= {pin_s2_q[2], shift_q[BYTE_W-2:0], pin_s2_q[1]};
    end
  end
  // pending until the buffer takes the byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else if (ovf) begin
      pend_q <= 1'b1;
    end else if (bufin_rdy) begin
      pend_q <= 1'b0;
    end
  end
  // hold level: drops on overflow, rises when byte is buffered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_q <= HOLD_RST;
    end else if (ovf) begin
      hold_q <= 1'b0;
    end else if (pend_q & bufin_rdy) begin
      hold_q <= 1'b1;
    end else if (cs_fall & ~pend_q) begin
      hold_q <= 1'b1;
    end
  end
  // hold pin floats while deselected
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link.busy_oe_b <= 1'b1;
    end else begin
      link.busy_oe_b <= pin_s2_q[3];
    end
  end
  assign link.busy_out = hold_q;

  // ----------------------------------------------------------------
  // buffer and routing
  // ----------------------------------------------------------------
  logic              bufout_vld;
  logic              bufout_rdy;
  logic [BYTE_W:0]   bufout;
  lcsp_fifo #(.W(BYTE_W+1), .D(BUF_D)) u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (pend_q),
    .in_ready  (bufin_rdy),
    .in_data   (cdreg_q),
    .out_valid (bufout_vld),
    .out_ready (bufout_rdy),
    .out_data  (bufout)
  );
  logic [DM_W-1:0]   dm_q [DEPTH];  // data memory
  logic [PW-1:0]     ptr_q;         // data pointer
  logic              rx_q;          // byte seen since select, command or data
  logic              commit_q;      // latch copy waiting
  logic              take;
  // drain stalls while an output slot is occupied
  assign bufout_rdy = ~cmd_valid & ~seg_valid;
  assign take       = bufout_vld & bufout_rdy;
  // command decoder handoff, all command codes passed on
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_valid <= 1'b0;
      cmd_code  <= '0;
    end else if (take & bufout[BYTE_W]) begin
      cmd_valid <= 1'b1;
      cmd_code  <= bufout[BYTE_W-1:0];
    end else if (cmd_ready) begin
      cmd_valid <= 1'b0;
    end
  end
  // segment decoder handoff for data bytes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seg_valid <= 1'b0;
      seg_byte  <= '0;
    end else if (take & ~bufout[BYTE_W] & seg_dec_en) begin
      seg_valid <= 1'b1;
      seg_byte  <= bufout[BYTE_W-1:0];
    end else if (seg_ready) begin
      seg_valid <= 1'b0;
    end
  end
  // data pointer: zero on select, advances per stored word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_q <= '0;
    end else if (cs_fall) begin
      ptr_q <= '0;
    end else if (take & ~bufout[BYTE_W] & ~seg_dec_en) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end
  // data memory write; cleared in reset so a commit that follows
  // command-only traffic copies defined words into the latch
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        dm_q[i] <= '0;
      end
    end else if (take & ~bufout[BYTE_W] & ~seg_dec_en) begin
      dm_q[ptr_q] <= bufout[DM_W-1:0];
    end
  end
  // remember input since select; commit once buffer is empty
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_q     <= 1'b0;
      commit_q <= 1'b0;
    end else begin
      if (cs_fall) begin
        rx_q <= 1'b0;
      end else if (ovf) begin
        rx_q <= 1'b1;
      end
      if (cs_rise & rx_q) begin
        commit_q <= 1'b1;
      end else if (~bufout_vld & ~pend_q) begin
        commit_q <= 1'b0;
      end
    end
  end
  // display latch copy
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      disp_latch <= '0;
    end else if (commit_q & ~bufout_vld & ~pend_q) begin
      for (int i = 0; i < DEPTH; i++) begin
        disp_latch[i*DM_W +: DM_W] <= dm_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // sync pin and frame timing
  // ----------------------------------------------------------------
  logic [1:0]    div_q = 2'h0;  // base clock divider, runs in reset
  logic [FW-1:0] frm_q;         // frame position
  // divider free runs so it can drive sync during reset
  always_ff @(posedge clk) begin
    div_q <= div_q + 1'b1;
  end
  // frame counter realigns on a foreign sync edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      frm_q <= '0;
    end else if (sync_fall && frm_q >= FW'(SYNC_IGN_CYC)) begin
      frm_q <= '0;
    end else if (frm_q == FW'(FRAME-1)) begin
      frm_q <= '0;
    end else begin
      frm_q <= frm_q + 1'b1;
    end
  end
  // open-drain drive: clock over four in reset, frame pulse after
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link.sync_oe_b <= div_q[1];
    end else begin
      link.sync_oe_b <= ~(frm_q < FW'(SYNC_LOW_CYC));
    end
  end
  assign link.sync_out = 1'b0;
  // frame start pulse for the drive logic
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= (frm_q == '0);
    end
  end
endmodule
`default_nettype wire

// file: pkg/lcsp_pkg.sv
// lcsp_pkg: constants and types shared by both ends of the serial
// command port of the lcd controller
// assumes: a single 100 MHz system clock on both ends
package lcsp_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;          // system clock period
  localparam int SCK_HALF_NS   = 200;         // least shift clock phase
  localparam int SCK_HALF_CYC  =              // rounded up, at least 1
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_GAP_CYC  = 8;           // wait for hold to drop
  localparam int OSC_DIV       = 4;           // sync divide during reset
  localparam int FRAME_CYC     = 1024;        // display frame length
  localparam int SYNC_LOW_CYC  = 4;           // own sync pulse width
  localparam int SYNC_IGN_CYC  = 8;           // own pulse echo window
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int BYTE_W        = 8;           // serial register width
  localparam int CNT_W         = 3;           // shift clock counter
  localparam int DM_W          = 4;           // data memory word
  localparam int DM_DEPTH      = 32;          // data memory words
  localparam int FIFO_DEPTH    = 8;           // received byte buffer
  localparam int CMD_COUNT     = 19;          // distinct commands
  // ----------------------------------------------------------------
  // reset and last-count values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST  = 3'h0;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
  localparam logic             HOLD_RST = 1'b1;  // accepting
  // host sequencer states
  typedef enum logic [2:0] {
    LCSP_H_IDLE  = 3'b000,
    LCSP_H_SEL   = 3'b001,
    LCSP_H_WAIT  = 3'b010,
    LCSP_H_LOW   = 3'b011,
    LCSP_H_HIGH  = 3'b100,
    LCSP_H_GAP   = 3'b101,
    LCSP_H_DESEL = 3'b110
  } lcsp_hstate_t;
endpackage

// file: pkg/lcsp_if.sv
// lcsp_if: the serial pins between host and lcd controller
// assumes: the bench drives sync_ext_b (other chips, high = idle)
`timescale 1ns/100ps
`default_nettype none
interface lcsp_if;
  logic sck_b;        // shift clock, idles high
  logic si;           // serial data, msb first
  logic cd;           // high = command, low = data
  logic cs_b;         // chip select, active low
  logic busy_out;     // hold output level from the device
  logic busy_oe_b;    // low while the device drives hold
  logic busy_b;       // resolved hold wire, pulled up
  logic sync_out;     // device sync drive level (always low)
  logic sync_oe_b;    // low while the device pulls sync low
  logic sync_ext_b;   // wired-or pull from other chips
  logic sync_b;       // resolved sync wire
  // pull-up on the floating hold pin
  assign busy_b = busy_oe_b ? 1'b1 : busy_out;
  // open-drain sync wire shared between chips
  assign sync_b = (sync_oe_b ? 1'b1 : sync_out) & sync_ext_b;
  modport dev  (input sck_b, si, cd, cs_b, sync_b,
                output busy_out, busy_oe_b, sync_out, sync_oe_b);
  modport host (output sck_b, si, cd, cs_b, input busy_b);
endinterface
`default_nettype wire

// file: design/lcsp_host.sv
// lcsp_host: host end that shifts bytes into the lcd controller
// assumes: the hold wire is pulled up while the device floats it
`timescale 1ns/100ps
`default_nettype none
module lcsp_host
  import lcsp_pkg::*;
#(
  parameter int HALF = lcsp_pkg::SCK_HALF_CYC,
  parameter int GAP  = lcsp_pkg::HOST_GAP_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // byte request
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic [BYTE_W-1:0] tx_byte,
  input  wire logic              tx_cmd,
  input  wire logic              tx_last,
  // link to device
  lcsp_if.host                   link
);
  import lcsp_pkg::*;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lcsp_hstate_t      st_q;       // sequencer state
  logic [7:0]        tmr_q;      // phase timer
  logic [CNT_W-1:0]  bit_q;      // bit being sent
  logic [BYTE_W-1:0] byte_q;     // byte being sent
  logic              last_q;     // deselect after this byte
  logic              busy_s1_q;  // hold sync, first stage
  logic              busy_s2_q;  // hold sync, second stage
  logic              tdone;
  assign tdone = (tmr_q == 8'h00);
  // hold wire passes two flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= link.busy_b;
      busy_s2_q <= busy_s1_q;
    end
  end
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q       <= LCSP_H_IDLE;
      tmr_q      <= 8'h00;
      bit_q      <= CNT_RST;
      byte_q     <= '0;
      last_q     <= 1'b0;
      tx_ready   <= 1'b0;
      link.sck_b <= 1'b1;
      link.si    <= 1'b0;
      link.cd    <= 1'b0;
      link.cs_b  <= 1'b1;
    end else begin
      if (!tdone) begin
        tmr_q <= tmr_q - 1'b1;
      end
      case (st_q)
        // wait for a byte
        LCSP_H_IDLE: begin
          tx_ready <= 1'b1;
          if (tx_valid & tx_ready) begin
            tx_ready <= 1'b0;
            byte_q   <= tx_byte;
            last_q   <= tx_last;
            link.cd  <= tx_cmd;
            tmr_q    <= 8'(HALF);
            if (link.cs_b) begin
              link.cs_b <= 1'b0;
              st_q      <= LCSP_H_SEL;
            end else begin
              st_q <= LCSP_H_WAIT;
            end
          end
        end
        // select setup time
        LCSP_H_SEL: begin
          if (tdone) begin
            st_q <= LCSP_H_WAIT;
          end
        end
        // wait for the device to accept
        LCSP_H_WAIT: begin
          if (busy_s2_q) begin
            bit_q  <= CNT_LAST;
            tmr_q  <= 8'(HALF);
            st_q   <= LCSP_H_LOW;
          end
        end
        // low phase, data presented msb first
        LCSP_H_LOW: begin
          link.sck_b <= 1'b0;
          link.si    <= byte_q[bit_q];
          if (tdone) begin
            tmr_q <= 8'(HALF);
            st_q  <= LCSP_H_HIGH;
          end
        end
        // high phase, device samples on the rise
        LCSP_H_HIGH: begin
          link.sck_b <= 1'b1;
          if (tdone) begin
            tmr_q <= 8'(HALF);
            if (bit_q == CNT_RST) begin
              tmr_q <= 8'(GAP);
              st_q  <= LCSP_H_GAP;
            end else begin
              bit_q <= bit_q - 1'b1;
              st_q  <= LCSP_H_LOW;
            end
          end
        end
        // let the device drop hold before looking again
        LCSP_H_GAP: begin
          if (tdone) begin
            tmr_q <= 8'(HALF);
            st_q  <= last_q ? LCSP_H_DESEL : LCSP_H_IDLE;
          end
        end
        // release select so the device commits the display
        LCSP_H_DESEL: begin
          link.cs_b <= 1'b1;
          if (tdone) begin
            st_q <= LCSP_H_IDLE;
          end
        end
        default: begin
          st_q <= LCSP_H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: dv/lcsp_chk.sv
// lcsp_chk: assertions on the pins between host and device ends
// assumes: instantiated once beside lcsp_if in the bench top
`timescale 1ns/100ps
`default_nettype none
module lcsp_chk (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // link pins
  input  wire logic sck_b,
  input  wire logic cs_b,
  input  wire logic busy_out,
  input  wire logic busy_oe_b,
  input  wire logic sync_out,
  input  wire logic sync_oe_b
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;  // raw shift clock rises in this byte
  logic       sck_q;  // shift clock level one cycle back
  // count rises while selected; hold low or deselect clears it
  always_ff @(posedge clk) begin
    sck_q <= sck_b;
    if (!rst_b || cs_b || !busy_out) begin
      cnt_q <= 4'h0;
    end else if (sck_b && !sck_q) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // divider in reset: two high, then two low, and back
  sequence s_deep_rst; !rst_b [*3]; endsequence
  sequence s_sync_hi2; sync_oe_b [*2]; endsequence
  sequence s_sync_lo2; !sync_oe_b [*2]; endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_float_desel: assert property (
    cs_b [*4] |-> busy_oe_b) else $error("hold driven deselected");
  chk_drive_sel: assert property (
    (!cs_b) [*4] |-> !busy_oe_b) else $error("hold not driven");
  chk_sync_open: assert property (
    !sync_out) else $error("sync driven high");
  chk_rst_div_hi: assert property (disable iff (rst_b)
    s_deep_rst ##0 s_sync_hi2 |=> s_sync_lo2)
    else $error("sync divider high phase wrong");
  chk_rst_div_lo: assert property (disable iff (rst_b)
    s_deep_rst ##0 s_sync_lo2 |=> s_sync_hi2)
    else $error("sync divider low phase wrong");
  chk_hold_eight: assert property (
    cnt_q == 4'h8 |-> ##[0:8] !busy_out)
    else $error("hold not dropped after eighth edge");
  chk_hold_cause: assert property (
    $fell(busy_out) |-> cnt_q == 4'h8)
    else $error("hold dropped before eighth edge");
  chk_hold_return: assert property (
    $fell(busy_out) |-> ##[1:1000] busy_out)
    else $error("hold never returned high");
  chk_frame_align: assert property (
    $rose(rst_b) |-> ##[0:4] !sync_oe_b)
    else $error("no frame sync after reset");
endmodule
`default_nettype wire

// file: dv/tb_lcd_ctrl_serial_cmd_port.sv
// tb_lcd_ctrl_serial_cmd_port: host and device ends over lcsp_if
// assumes: lcsp_pkg, lcsp_if, design and checker compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    total_checks++; \
    if ((gt) !== (ex)) begin \
      n_fail++; \
      $display("FAIL %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module tb_lcd_ctrl_serial_cmd_port;
  import lcsp_pkg::*;
  logic                     clk        = 1'b0;  // system clock
  logic                     rst_b      = 1'b0;  // reset, active low
  logic                     tx_valid   = 1'b0;  // byte offered
  logic                     tx_cmd     = 1'b0;  // byte is a command
  logic                     tx_last    = 1'b0;  // deselect after it
  logic [7:0]               tx_byte    = 8'h00; // byte to send
  logic                     cmd_ready  = 1'b1;  // command sink
  logic                     seg_dec_en = 1'b0;  // data to segments
  logic                     tx_ready, cmd_valid, seg_valid;
  logic [7:0]               cmd_code, seg_byte;
  logic [DM_DEPTH*DM_W-1:0] disp_latch;         // display latch
  logic [7:0]               cmd_q[$], seg_q[$]; // bytes at sinks
  int                       n_fail = 0, total_checks = 0;
  lcsp_if link_if ();
  logic                     sync_ext_b = 1'b1;  // other chips, 1 = idle
  logic                     frame_tick;         // frame start pulse
  assign link_if.sync_ext_b = sync_ext_b;
  always #5 clk = ~clk;
  lcsp_host #(.HALF(4)) lcsp_host_i (.clk(clk), .rst_b(rst_b),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .tx_cmd(tx_cmd), .tx_last(tx_last), .link(link_if.host));
  lcsp_dev #(.FRAME(64)) lcsp_dev_i (.clk(clk), .rst_b(rst_b),
    .link(link_if.dev), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .seg_dec_en(seg_dec_en), .seg_ready(1'b1),
    .seg_valid(seg_valid), .seg_byte(seg_byte),
    .disp_latch(disp_latch), .frame_tick(frame_tick));
  lcsp_chk lcsp_chk_i (.clk(clk), .rst_b(rst_b), .sck_b(link_if.sck_b),
    .cs_b(link_if.cs_b), .busy_out(link_if.busy_out),
    .busy_oe_b(link_if.busy_oe_b), .sync_out(link_if.sync_out),
    .sync_oe_b(link_if.sync_oe_b));
  // collect bytes handed over at the sinks
  always @(posedge clk) begin
    if (cmd_valid === 1'b1 && cmd_ready) begin
      cmd_q.push_back(cmd_code);
    end
    if (seg_valid === 1'b1) begin
      seg_q.push_back(seg_byte);
    end
  end
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // wait for host idle; a hang ends the run
  task automatic wait_idle(input int lim);
    for (int k = 0; tx_ready !== 1'b1; k++) begin
      if (k > lim) begin
        n_fail++;
        give_verdict();
      end
      @(negedge clk);
    end
  endtask
  // offer one byte at a falling edge
  task automatic send(input logic [7:0] b, input logic c, l);
    wait_idle(2000);
    {tx_byte, tx_cmd, tx_last, tx_valid} = {b, c, l, 1'b1};
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  // reset held twelve cycles
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // wait for the latch to settle, then compare
  task automatic chk_latch(input logic [DM_DEPTH*DM_W-1:0] e);
    wait_idle(2000);
    for (int k = 0; k < 20 && disp_latch !== e; k++) begin
      @(negedge clk);
    end
    `CHK("disp latch", e, disp_latch);
  endtask
  // all command codes in a row, msb first
  task automatic t_cmds();
    for (int i = 0; i < CMD_COUNT; i++) begin
      send(8'h81 ^ 8'(i * 37), 1'b1, i == CMD_COUNT - 1);
    end
    chk_latch('0);
    `CHK("cmd count", CMD_COUNT, cmd_q.size());
    for (int i = 0; i < CMD_COUNT; i++) begin
      `CHK("cmd code", 8'h81 ^ 8'(i * 37), cmd_q[i]);
    end
  endtask
  // data frame, early look, then reselect overwrites word zero
  task automatic t_data();
    logic [DM_DEPTH*DM_W-1:0] e;
    e = '0;
    cmd_q.delete();
    for (int i = 0; i < 4; i++) begin
      send(8'hF9 + 8'(i), 1'b0, i == 3);
      e[i*4 +: 4] = 4'(i + 9);
      if (i == 2) begin
        wait_idle(2000);
        `CHK("latch early", '0, disp_latch);
      end
    end
    chk_latch(e);
    send(8'h05, 1'b0, 1'b1);
    e[3:0] = 4'h5;
    chk_latch(e);
    `CHK("data as cmd", 0, cmd_q.size());
  endtask
  // data to the segment path
  task automatic t_seg();
    seg_dec_en = 1'b1;
    send(8'h3C, 1'b0, 1'b1);
    wait_idle(2000);
    `CHK("seg byte", 8'h3C, seg_q[0]);
    seg_dec_en = 1'b0;
  endtask
  // stall the command sink until hold refuses, then drain
  task automatic t_fill();
    int n;
    cmd_q.delete();
    cmd_ready = 1'b0;
    for (n = 0; n < 20; n++) begin
      send(8'(n + 8'h40), 1'b1, 1'b0);
      for (int k = 0; k < 400 && tx_ready !== 1'b1; k++) begin
        @(negedge clk);
      end
      if (tx_ready !== 1'b1) begin
        break;
      end
    end
    `CHK("hold refuse", 1'b0, link_if.busy_b);
    `CHK("buffered", 1'b1, n >= FIFO_DEPTH);
    cmd_ready = 1'b1;
    send(8'(n + 8'h41), 1'b1, 1'b1);
    wait_idle(2000);
    `CHK("drained", n + 2, cmd_q.size());
    for (int i = 0; i < n + 2; i++) begin
      `CHK("fill code", 8'(i + 8'h40), cmd_q[i]);
    end
  endtask
  // foreign sync pulse mid-frame realigns the frame counter
  task automatic t_sync();
    for (int k = 0; k < 200 && frame_tick !== 1'b1; k++) begin
      @(negedge clk);
    end
    `CHK("tick seen", 1'b1, frame_tick);
    repeat (20) @(negedge clk);
    sync_ext_b = 1'b0;
    repeat (2) @(negedge clk);
    sync_ext_b = 1'b1;
    @(negedge clk);
    `CHK("tick early", 1'b0, frame_tick);
    @(negedge clk);
    `CHK("frame realign", 1'b1, frame_tick);
    repeat (64) @(negedge clk);
    `CHK("frame period", 1'b1, frame_tick);
  endtask
  // main sequence
  initial begin
    do_reset();
    t_cmds();
    t_data();
    t_seg();
    t_fill();
    t_sync();
    do_reset();
    `CHK("latch reset", '0, disp_latch);
    `CHK("hold float", 1'b1, link_if.busy_b);
    give_verdict();
  end
endmodule
`default_nettype wire
